// >>> sfdr_checker.sv
// Purpose: Port-level checks of sfdr_top.
// Assumes: Sees only the ports of sfdr_top.
// Notes: Bound to sfdr_top below the module.
`timescale 1ns/1ps
`default_nettype none
module sfdr_checker #(
  parameter int ENTRY_CYC = 8,
  parameter int WAKE_CYC = 8,
  parameter int WAKE_ID_CYC = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic serial_in_line_i,
  input wire logic serial_in_line_o,
  input wire logic serial_in_line_oe,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic core_busy,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd_stb,
  input wire logic [7:0] mem_rd_data,
  input wire logic deep_sleep
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************************************************************
  // Select-high run length
  // ****************************************************************
  // Saturates so that a long idle never wraps back into range.
  logic [15:0] hi_cnt_ff, nxt_hi_cnt;
  always_comb begin
    nxt_hi_cnt = hi_cnt_ff;
    if (rst || !spi_cs_n) begin
      nxt_hi_cnt = 16'h0000;
    end else if (hi_cnt_ff != 16'hffff) begin
      nxt_hi_cnt = hi_cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    hi_cnt_ff <= nxt_hi_cnt;
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Timer bounds allow for the pin synchronisers and edge detection.
  reset_quiet_a:
    assert property (disable iff (1'b0) rst |=> !serial_out_oe && !serial_in_line_oe && !deep_sleep)
    else $error("output active after reset");
  dual_pair_a:
    assert property (serial_in_line_oe |-> serial_out_oe) else $error("input line driven alone");
  cs_abort_a:
    assert property (spi_cs_n [*6] |-> !serial_out_oe && !serial_in_line_oe)
    else $error("drive kept after select high");
  sleep_quiet_a:
    assert property (deep_sleep |-> !serial_in_line_oe) else $error("dual drive while asleep");
  sleep_entry_a:
    assert property ($rose(deep_sleep) |-> spi_cs_n && hi_cnt_ff >= ENTRY_CYC
      && hi_cnt_ff <= ENTRY_CYC + 10) else $error("sleep entry timing wrong");
  wake_time_a:
    assert property ($fell(deep_sleep) |-> spi_cs_n && hi_cnt_ff >= WAKE_CYC
      && hi_cnt_ff <= WAKE_ID_CYC + 10) else $error("wake timing wrong");
  stb_pulse_a:
    assert property (mem_rd_stb |-> !spi_cs_n ##1 !mem_rd_stb) else $error("bad read strobe");
  hold_data_a:
    assert property (serial_out_oe && spi_sck && $past(spi_sck, 3) |->
      $stable(serial_out_o) && $stable(serial_in_line_o)) else $error("data moved while clock high");
  cover property ($rose(deep_sleep));
  cover property ($fell(deep_sleep));
  cover property ($rose(serial_in_line_oe));
endmodule
bind sfdr_top sfdr_checker #(
  .ENTRY_CYC(ENTRY_CYC), .WAKE_CYC(WAKE_CYC), .WAKE_ID_CYC(WAKE_ID_CYC)
) u_sfdr_checker (
  .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
  .serial_in_line_i(serial_in_line_i), .serial_in_line_o(serial_in_line_o),
  .serial_in_line_oe(serial_in_line_oe), .serial_out_o(serial_out_o),
  .serial_out_oe(serial_out_oe), .core_busy(core_busy), .mem_addr(mem_addr),
  .mem_rd_stb(mem_rd_stb), .mem_rd_data(mem_rd_data), .deep_sleep(deep_sleep)
);
`default_nettype wire

// >>> sfdr_host.sv
// Purpose: Behavioural serial host driving select, clock and input line.
// Assumes: Serial clock of 200 ns, mode 0, four core clocks a phase.
// Notes: Also resolves both data lines from all drivers.
`timescale 1ns/1ps
`default_nettype none
module sfdr_host (
  input wire logic clk,
  input wire logic dev_so_o,
  input wire logic dev_so_oe,
  input wire logic dev_si_o,
  input wire logic dev_si_oe,
  output logic cs_n,
  output logic sck,
  output logic di_level
);
  logic drv_oe, drv_d, di_q, so_q, so_level, drove;
  // An undriven line shows the inverse of its last level, so stale data never matches.
  assign di_level = dev_si_oe ? dev_si_o : (drv_oe ? drv_d : ~di_q);
  assign so_level = dev_so_oe ? dev_so_o : ~so_q;
  always @(posedge clk) begin
    di_q <= di_level;
    so_q <= so_level;
  end
  initial begin
    {cs_n, sck, drv_oe, drv_d, di_q, so_q, drove} = 7'h40;
  end
  // One serial clock; the sample taken before the fall holds the previous fall's bit.
  task automatic bitcyc(input logic b, input logic rel, output logic so, output logic si);
    begin
      drv_d <= b;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (3) @(posedge clk);
      if (rel) drv_oe <= 1'b0;
      @(posedge clk);
      so = so_level;
      si = di_level;
      drove = drove | dev_so_oe | dev_si_oe;
      sck <= 1'b0;
    end
  endtask
  task automatic start();
    begin
      cs_n <= 1'b0;
      drv_oe <= 1'b1;
      drove = 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // Select goes high four clocks after the last fall and stays high eight clocks.
  task automatic stop();
    begin
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      drv_oe <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic send(input logic [31:0] v, input int n, input logic rel);
    logic so, si;
    begin
      for (int i = n - 1; i >= 0; i--) bitcyc(v[i], rel && i == 0, so, si);
    end
  endtask
  task automatic recv(input int n, output logic [127:0] so_v, output logic [127:0] si_v);
    logic so, si;
    begin
      so_v = '0;
      si_v = '0;
      for (int i = 0; i < n; i++) begin
        bitcyc(1'b0, 1'b0, so, si);
        so_v = {so_v[126:0], so};
        si_v = {si_v[126:0], si};
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> sfdr_pkg.sv
// Purpose: Types of the serial flash dual-read, ident and sleep interpreter.
// Assumes: Nothing beyond the shared constants header.
// Notes: Used by full scope name only.
package sfdr_pkg;

  // ****************************************************************
  // Frame phases
  // ****************************************************************
  typedef enum logic [2:0] {
    SFDR_ST_CMD    = 3'b000,
    SFDR_ST_ADDR   = 3'b001,
    SFDR_ST_DUMMY  = 3'b010,
    SFDR_ST_DATA   = 3'b011,
    SFDR_ST_IGNORE = 3'b100
  } sfdr_state_t;

  // ****************************************************************
  // Instruction codes handled here
  // ****************************************************************
  typedef enum logic [7:0] {
    SFDR_CMD_DUAL_READ  = 8'h3b,
    SFDR_CMD_SLEEP      = 8'hb9,
    SFDR_CMD_WAKE_ID    = 8'hab,
    SFDR_CMD_MFR_DEV    = 8'h90,
    SFDR_CMD_STD_IDENT  = 8'h9f,
    SFDR_CMD_UNIQUE_ID  = 8'h4b
  } sfdr_cmd_t;

endpackage

// >>> sfdr_regs.svh
// Purpose: Shared constants of the serial flash dual-read, ident and sleep interpreter.
// Assumes: Core clock of 40 MHz.
// Notes: Times are in ns as printed; cycle counts derive from them.
`ifndef SFDR_REGS_SVH
`define SFDR_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define SFDR_CLK_MHZ 40
`define SFDR_T_ENTRY_NS 3000
`define SFDR_T_WAKE_NS 3000
`define SFDR_T_WAKE_ID_NS 5000
// Longest times round down to whole cycles.
`define SFDR_ENTRY_CYC ((`SFDR_T_ENTRY_NS * `SFDR_CLK_MHZ) / 1000)
`define SFDR_WAKE_CYC ((`SFDR_T_WAKE_NS * `SFDR_CLK_MHZ) / 1000)
`define SFDR_WAKE_ID_CYC ((`SFDR_T_WAKE_ID_NS * `SFDR_CLK_MHZ) / 1000)

// ****************************************************************
// Frame layout
// ****************************************************************
`define SFDR_CMD_LAST 5'h07
`define SFDR_ADDR_LAST 5'h17
`define SFDR_DUMMY8_LAST 5'h07
`define SFDR_DUMMY24_LAST 5'h17
`define SFDR_ADDR_SWAP 24'h000001
`define SFDR_RST_CNT 5'h00
`define SFDR_RST_TMR 16'h0000
`define SFDR_IDX_STD_LAST 4'h2

`endif

// >>> sfdr_sync.sv
// Purpose: Two-stage synchroniser for the serial pins.
// Assumes: Inputs are asynchronous to clk.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
`default_nettype none
module sfdr_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // Per-bit double flop
  // ****************************************************************
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("sfdr_sync needs WIDTH of at least one.");
    end
  endgenerate

  // The first stage feeds the second stage only.
  always_comb begin
    nxt_meta = async_in;
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_ff[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= nxt_meta[gi];
          sync_out[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sfdr_top.sv
// Purpose: Serial command interpreter for dual read, ident reads and deep sleep.
// Assumes: Serial clock is sampled by clk and runs well below a quarter of it.
// Notes: Pins pass two flops; all outputs are registered.
//
// Functional notes
// [RULE1] Instruction 3Bh returns read data on both output and input lines.
// [RULE2] Dual read has 24 address bits, eight ignored dummy clocks, then data.
// [RULE3] Host releases the input line before the first data falling edge.
// [RULE4] B9h sleeps only if select rises right after bit eight.
// [RULE5] In deep sleep only ABh is recognised, all else ignored.
// [RULE6] After reset the device is awake and in standby.
// [RULE7] ABh alone then select high wakes after the wake delay.
// [RULE8] ABh with three dummy bytes streams the device ID, MSB first, repeating.
// [RULE9] ID form of ABh from sleep uses the longer wake delay.
// [RULE10] ABh while busy is ignored and leaves the running cycle alone.
// [RULE11] 90h at address zero sends manufacturer then device ID, repeating.
// [RULE12] 90h at address one sends device ID first, alternating.
// [RULE13] 9Fh sends manufacturer, memory type byte, capacity byte, MSB first.
// [RULE14] 4Bh, zero address, one dummy byte, then the 128-bit unique number.
// [RULE15] Instruction and address bits are sampled on serial clock rising edges.
// [RULE16] Dual data: odd bit on output line, even bit on input line.
// [RULE17] Select high aborts any transfer and waits for a new instruction.
`include "sfdr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sfdr_top #(
  parameter logic [7:0] MFR_ID = 8'h5a,   // Arbitrary value.
  parameter logic [7:0] DEV_ID = 8'h12,   // Arbitrary value.
  parameter logic [7:0] MEM_TYPE = 8'h60, // Arbitrary value.
  parameter logic [7:0] CAPACITY = 8'h13, // Arbitrary value.
  parameter int ENTRY_CYC = `SFDR_ENTRY_CYC,
  parameter int WAKE_CYC = `SFDR_WAKE_CYC,
  parameter int WAKE_ID_CYC = `SFDR_WAKE_ID_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic serial_in_line_i,
  output logic serial_in_line_o,
  output logic serial_in_line_oe,
  output logic serial_out_o,
  output logic serial_out_oe,
  input wire logic core_busy,
  output logic [23:0] mem_addr,
  output logic mem_rd_stb,
  input wire logic [7:0] mem_rd_data,
  output logic deep_sleep
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (ENTRY_CYC < 1 || ENTRY_CYC > 65535 || WAKE_CYC < 1 || WAKE_CYC > 65535 ||
        WAKE_ID_CYC < 1 || WAKE_ID_CYC > 65535) begin : g_bad
      $error("sfdr_top delay counts must lie between 1 and 65535.");
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] pins_sync;
  logic cs_s;
  logic sck_s;
  logic di_s;
  logic cs_q_ff;
  logic sck_q_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic [7:0] uid_byte;

  sfdr_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({spi_cs_n, spi_sck, serial_in_line_i}),
    .sync_out(pins_sync)
  );

  // Edges are found on the synchronised copies only.
  assign cs_s = pins_sync[2];
  assign sck_s = pins_sync[1];
  assign di_s = pins_sync[0];
  assign sck_rise = sck_s & ~sck_q_ff;
  assign sck_fall = ~sck_s & sck_q_ff;
  assign cs_rise = cs_s & ~cs_q_ff;

  // ****************************************************************
  // Interpreter state
  // ****************************************************************
  sfdr_pkg::sfdr_state_t state_ff, nxt_state;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [23:0] addr_ff, nxt_addr;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [3:0] idx_ff, nxt_idx;
  logic [7:0] sr_ff, nxt_sr;
  logic [2:0] bitpos_ff, nxt_bitpos;
  logic sleep_arm_ff, nxt_sleep_arm;
  logic wake_arm_ff, nxt_wake_arm;
  logic wake_long_ff, nxt_wake_long;
  logic [15:0] tmr_ff, nxt_tmr;
  logic tmr_sleep_ff, nxt_tmr_sleep;
  logic asleep_ff, nxt_asleep;
  logic so_ff, nxt_so;
  logic so_oe_ff, nxt_so_oe;
  logic si_ff, nxt_si;
  logic si_oe_ff, nxt_si_oe;
  logic [23:0] mem_addr_ff, nxt_mem_addr;
  logic mem_stb_ff, nxt_mem_stb;
  logic [7:0] shifted_cmd;
  logic [7:0] src_byte;
  logic dual;

  sfdr_uid_rom #(
    .BYTES(16)
  ) u_uid (
    .clk(clk),
    .rst(rst),
    .rd_idx(idx_ff),
    .rd_data(uid_byte)
  );

  assign shifted_cmd = {cmd_ff[6:0], di_s};
  assign dual = (cmd_ff == sfdr_pkg::SFDR_CMD_DUAL_READ);

  // Byte source for the next data byte, chosen by instruction.
  always_comb begin
    case (cmd_ff)
      sfdr_pkg::SFDR_CMD_DUAL_READ: src_byte = mem_rd_data;
      sfdr_pkg::SFDR_CMD_WAKE_ID: src_byte = DEV_ID; // see [RULE8]
      // Bit zero of the address picks which byte leads; see [RULE11] see [RULE12]
      sfdr_pkg::SFDR_CMD_MFR_DEV: src_byte = (idx_ff[0] ^ addr_ff[0]) ? DEV_ID : MFR_ID;
      sfdr_pkg::SFDR_CMD_STD_IDENT: begin
        case (idx_ff)
          4'h0: src_byte = MFR_ID; // see [RULE13]
          4'h1: src_byte = MEM_TYPE;
          default: src_byte = CAPACITY;
        endcase
      end
      sfdr_pkg::SFDR_CMD_UNIQUE_ID: src_byte = uid_byte; // see [RULE14]
      default: src_byte = 8'h00;
    endcase
  end

  // Next-state logic for the whole frame, sleep timer and pin drivers.
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_sr = sr_ff;
    nxt_bitpos = bitpos_ff;
    nxt_sleep_arm = sleep_arm_ff;
    nxt_wake_arm = wake_arm_ff;
    nxt_wake_long = wake_long_ff;
    nxt_tmr = tmr_ff;
    nxt_tmr_sleep = tmr_sleep_ff;
    nxt_asleep = asleep_ff;
    nxt_so = so_ff;
    nxt_so_oe = so_oe_ff;
    nxt_si = si_ff;
    nxt_si_oe = si_oe_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_stb = 1'b0;

    // Sleep entry and wake timers; the state flips when the count runs out.
    if (tmr_ff != `SFDR_RST_TMR) begin
      nxt_tmr = tmr_ff - 16'h0001;
      if (tmr_ff == 16'h0001) begin
        nxt_asleep = tmr_sleep_ff; // see [RULE4] see [RULE7] see [RULE9]
      end
    end

    if (cs_s) begin
      // Select high ends every transfer and releases both lines.
      nxt_state = sfdr_pkg::SFDR_ST_CMD; // see [RULE17]
      nxt_cnt = `SFDR_RST_CNT;
      nxt_so_oe = 1'b0;
      nxt_si_oe = 1'b0;
      nxt_sleep_arm = 1'b0;
      nxt_wake_arm = 1'b0;
      nxt_wake_long = 1'b0;
      if (cs_rise && sleep_arm_ff) begin
        nxt_tmr = 16'(ENTRY_CYC); // see [RULE4]
        nxt_tmr_sleep = 1'b1;
      end else if (cs_rise && wake_arm_ff) begin
        // The ID form stays asleep longer before new instructions count.
        nxt_tmr = wake_long_ff ? 16'(WAKE_ID_CYC) : 16'(WAKE_CYC); // see [RULE7] see [RULE9]
        nxt_tmr_sleep = 1'b0;
      end
    end else if (sck_rise) begin
      // Every clock after the eighth bit spoils a pending sleep entry.
      nxt_sleep_arm = 1'b0; // see [RULE4]
      if (wake_arm_ff) begin
        nxt_wake_long = 1'b1;
      end
      case (state_ff)
        sfdr_pkg::SFDR_ST_CMD: begin
          nxt_cmd = shifted_cmd; // see [RULE15]
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == `SFDR_CMD_LAST) begin
            nxt_cnt = `SFDR_RST_CNT;
            nxt_idx = 4'h0;
            nxt_bitpos = 3'h0;
            nxt_state = sfdr_pkg::SFDR_ST_IGNORE;
            // A frame whose eighth bit arrives during a pending sleep or wake delay is dropped.
            if (tmr_ff != `SFDR_RST_TMR) begin
              nxt_state = sfdr_pkg::SFDR_ST_IGNORE;
            end else if (shifted_cmd == sfdr_pkg::SFDR_CMD_WAKE_ID) begin
              if (!core_busy) begin // see [RULE10]
                nxt_state = sfdr_pkg::SFDR_ST_DUMMY;
                nxt_wake_arm = asleep_ff; // see [RULE7]
              end
            end else if (asleep_ff) begin
              nxt_state = sfdr_pkg::SFDR_ST_IGNORE; // see [RULE5]
            end else begin
              case (shifted_cmd)
                sfdr_pkg::SFDR_CMD_DUAL_READ,
                sfdr_pkg::SFDR_CMD_MFR_DEV,
                sfdr_pkg::SFDR_CMD_UNIQUE_ID: nxt_state = sfdr_pkg::SFDR_ST_ADDR;
                sfdr_pkg::SFDR_CMD_STD_IDENT: nxt_state = sfdr_pkg::SFDR_ST_DATA;
                sfdr_pkg::SFDR_CMD_SLEEP: nxt_sleep_arm = 1'b1; // see [RULE4]
                default: nxt_state = sfdr_pkg::SFDR_ST_IGNORE;
              endcase
            end
          end
        end
        sfdr_pkg::SFDR_ST_ADDR: begin
          nxt_addr = {addr_ff[22:0], di_s}; // see [RULE15]
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == `SFDR_ADDR_LAST) begin
            nxt_cnt = `SFDR_RST_CNT;
            nxt_mem_addr = {addr_ff[22:0], di_s};
            nxt_mem_stb = 1'b1;
            nxt_state = (cmd_ff == sfdr_pkg::SFDR_CMD_MFR_DEV) ? sfdr_pkg::SFDR_ST_DATA :
                        sfdr_pkg::SFDR_ST_DUMMY; // see [RULE2] see [RULE14]
          end
        end
        sfdr_pkg::SFDR_ST_DUMMY: begin
          // Input values are not looked at during dummy clocks.
          nxt_cnt = cnt_ff + 5'h01; // see [RULE2]
          if ((cmd_ff == sfdr_pkg::SFDR_CMD_WAKE_ID && cnt_ff == `SFDR_DUMMY24_LAST) ||
              (cmd_ff != sfdr_pkg::SFDR_CMD_WAKE_ID && cnt_ff == `SFDR_DUMMY8_LAST)) begin
            nxt_cnt = `SFDR_RST_CNT;
            nxt_state = sfdr_pkg::SFDR_ST_DATA; // see [RULE8]
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end else if (sck_fall && state_ff == sfdr_pkg::SFDR_ST_DATA) begin
      // Data leaves on falling edges, MSB first; a new byte loads at position zero.
      nxt_so_oe = 1'b1;
      nxt_si_oe = dual; // see [RULE1] see [RULE3]
      if (bitpos_ff == 3'h0) begin
        nxt_so = src_byte[7];
        nxt_si = src_byte[6]; // see [RULE16]
        nxt_sr = dual ? {src_byte[5:0], 2'b00} : {src_byte[6:0], 1'b0};
        nxt_idx = (cmd_ff == sfdr_pkg::SFDR_CMD_STD_IDENT && idx_ff == `SFDR_IDX_STD_LAST) ?
                  4'h0 : idx_ff + 4'h1;
        nxt_mem_addr = mem_addr_ff + 24'h000001;
        nxt_mem_stb = dual;
      end else begin
        nxt_so = sr_ff[7];
        nxt_si = sr_ff[6];
        nxt_sr = dual ? {sr_ff[5:0], 2'b00} : {sr_ff[6:0], 1'b0};
      end
      // Dual mode moves a pair per edge, so a byte takes four edges.
      if (dual) begin
        nxt_bitpos = (bitpos_ff == 3'h3) ? 3'h0 : bitpos_ff + 3'h1; // see [RULE16]
      end else begin
        nxt_bitpos = bitpos_ff + 3'h1;
      end
    end
  end

  // Register stage; reset leaves the part awake and idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= sfdr_pkg::SFDR_ST_CMD;
      cmd_ff <= 8'h00;
      addr_ff <= 24'h000000;
      cnt_ff <= `SFDR_RST_CNT;
      idx_ff <= 4'h0;
      sr_ff <= 8'h00;
      bitpos_ff <= 3'h0;
      sleep_arm_ff <= 1'b0;
      wake_arm_ff <= 1'b0;
      wake_long_ff <= 1'b0;
      tmr_ff <= `SFDR_RST_TMR;
      tmr_sleep_ff <= 1'b0;
      asleep_ff <= 1'b0; // see [RULE6]
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      si_ff <= 1'b0;
      si_oe_ff <= 1'b0;
      mem_addr_ff <= 24'h000000;
      mem_stb_ff <= 1'b0;
      cs_q_ff <= 1'b1;
      sck_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      sr_ff <= nxt_sr;
      bitpos_ff <= nxt_bitpos;
      sleep_arm_ff <= nxt_sleep_arm;
      wake_arm_ff <= nxt_wake_arm;
      wake_long_ff <= nxt_wake_long;
      tmr_ff <= nxt_tmr;
      tmr_sleep_ff <= nxt_tmr_sleep;
      asleep_ff <= nxt_asleep;
      so_ff <= nxt_so;
      so_oe_ff <= nxt_so_oe;
      si_ff <= nxt_si;
      si_oe_ff <= nxt_si_oe;
      mem_addr_ff <= nxt_mem_addr;
      mem_stb_ff <= nxt_mem_stb;
      cs_q_ff <= cs_s;
      sck_q_ff <= sck_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign serial_out_o = so_ff;
  assign serial_out_oe = so_oe_ff;
  assign serial_in_line_o = si_ff;
  assign serial_in_line_oe = si_oe_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_rd_stb = mem_stb_ff;
  assign deep_sleep = asleep_ff;

endmodule
`default_nettype wire

// >>> sfdr_top_bench.sv
// Purpose: Self-checking bench of sfdr_top.
// Assumes: Host model sfdr_host; core answers reads after one clock.
// Notes: Short timer parameters keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module sfdr_top_bench;
  localparam int ENTRY = 8;
  localparam int WAKE = 8;
  localparam int WAKE_ID = 12;
  localparam logic [7:0] MFR = 8'hc3; // Arbitrary value.
  localparam logic [7:0] DEV = 8'h2d; // Arbitrary value.
  localparam logic [7:0] TYP = 8'h71; // Arbitrary value.
  localparam logic [7:0] CAP = 8'h15; // Arbitrary value.
  // Arbitrary value; it must equal the unique number held in the store.
  localparam logic [127:0] UID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  logic clk, rst, cs_n, sck, di_level, si_o, si_oe, so_o, so_oe, core_busy, mem_rd_stb;
  logic deep_sleep;
  logic [23:0] mem_addr;
  logic [7:0] mem_rd_data;
  logic [127:0] so_v, si_v;
  int miscompares, n_checks;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The core model returns a pattern tied to the address.
  always @(posedge clk) mem_rd_data <= mem_addr[7:0] ^ 8'h5c;
  sfdr_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP),
    .ENTRY_CYC(ENTRY), .WAKE_CYC(WAKE), .WAKE_ID_CYC(WAKE_ID)) u_sfdr_top (
    .clk(clk), .rst(rst), .spi_cs_n(cs_n), .spi_sck(sck), .serial_in_line_i(di_level),
    .serial_in_line_o(si_o), .serial_in_line_oe(si_oe), .serial_out_o(so_o),
    .serial_out_oe(so_oe), .core_busy(core_busy), .mem_addr(mem_addr),
    .mem_rd_stb(mem_rd_stb), .mem_rd_data(mem_rd_data), .deep_sleep(deep_sleep));
  sfdr_host u_sfdr_host (.clk(clk), .dev_so_o(so_o), .dev_so_oe(so_oe), .dev_si_o(si_o),
    .dev_si_oe(si_oe), .cs_n(cs_n), .sck(sck), .di_level(di_level));
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    begin
      n_checks++;
      if (got !== exp) begin
        miscompares++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic test_done();
    begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // One whole frame: code, address, dummy bits, then nr bits read back.
  task automatic frame(input logic [7:0] c, input logic [23:0] a, input int na, input int nd,
    input int nr);
    begin
      u_sfdr_host.start();
      u_sfdr_host.send({24'h0, c}, 8, 1'b0);
      u_sfdr_host.send({8'h0, a}, na, 1'b0);
      u_sfdr_host.send(32'h0, nd, c == 8'h3b);
      u_sfdr_host.recv(nr, so_v, si_v);
      u_sfdr_host.stop();
    end
  endtask
  task automatic t_ident();
    begin
      frame(8'h9f, 24'h0, 0, 0, 32);
      chk("standard ident", {MFR, TYP, CAP, MFR}, so_v[31:0]);
      frame(8'h90, 24'h0, 24, 0, 32);
      chk("ids from zero", {MFR, DEV, MFR, DEV}, so_v[31:0]);
      frame(8'h90, 24'h1, 24, 0, 32);
      chk("ids from one", {DEV, MFR, DEV, MFR}, so_v[31:0]);
      frame(8'hab, 24'h0, 24, 0, 16);
      chk("device id", {DEV, DEV}, so_v[15:0]);
      frame(8'h4b, 24'h0, 24, 8, 128);
      chk("unique number", UID, so_v);
      frame(8'h9f, 24'h0, 0, 0, 4);
      frame(8'h9f, 24'h0, 0, 0, 8);
      chk("after abort", MFR, so_v[7:0]);
    end
  endtask
  // Two bytes across a byte boundary, split over both lines.
  task automatic t_dual();
    logic [15:0] w;
    logic [7:0] eo, ei;
    begin
      w = {8'hff ^ 8'h5c, 8'h00 ^ 8'h5c};
      for (int i = 0; i < 8; i++) begin
        eo[7 - i] = w[15 - 2 * i];
        ei[7 - i] = w[14 - 2 * i];
      end
      frame(8'h3b, 24'h0000ff, 24, 8, 8);
      chk("dual output line", eo, so_v[7:0]);
      chk("dual input line", ei, si_v[7:0]);
      // Nine falls start three bytes, so the address has moved on three times.
      chk("dual address", 24'h000102, mem_addr);
    end
  endtask
  task automatic t_sleep();
    begin
      core_busy <= 1'b1;
      frame(8'hab, 24'h0, 24, 0, 8);
      chk("drive while busy", 1'b0, u_sfdr_host.drove);
      core_busy <= 1'b0;
      frame(8'hb9, 24'h0, 1, 0, 0);
      repeat (ENTRY + 20) @(posedge clk);
      chk("sleep with extra clock", 1'b0, deep_sleep);
      frame(8'hb9, 24'h0, 0, 0, 0);
      repeat (ENTRY + 20) @(posedge clk);
      chk("sleep entered", 1'b1, deep_sleep);
      frame(8'h9f, 24'h0, 0, 0, 8);
      chk("ident while asleep", 1'b0, u_sfdr_host.drove);
      frame(8'h3b, 24'h0, 24, 8, 8);
      chk("dual while asleep", 1'b0, u_sfdr_host.drove);
      frame(8'hab, 24'h0, 0, 0, 0);
      repeat (WAKE + 20) @(posedge clk);
      chk("woken", 1'b0, deep_sleep);
      frame(8'hb9, 24'h0, 0, 0, 0);
      repeat (ENTRY + 20) @(posedge clk);
      frame(8'hab, 24'h0, 24, 0, 8);
      chk("id on wake", DEV, so_v[7:0]);
      repeat (WAKE_ID + 20) @(posedge clk);
      chk("woken with id", 1'b0, deep_sleep);
      frame(8'h9f, 24'h0, 0, 0, 8);
      chk("ident after wake", MFR, so_v[7:0]);
    end
  endtask
  initial begin
    rst = 1'b1;
    core_busy = 1'b0;
    mem_rd_data = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("awake after reset", 1'b0, deep_sleep);
    t_ident();
    t_dual();
    t_sleep();
    test_done();
  end
  // Cuts a hang short; the tests need about 5650 clocks.
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire

// >>> sfdr_uid_rom.sv
// Purpose: Read-only store of the 128-bit unique number, one byte per read.
// Assumes: Index is stable one cycle before the data is used.
// Notes: Read data comes from a register.
`timescale 1ns/1ps
`default_nettype none
module sfdr_uid_rom #(
  parameter int BYTES = 16,
  parameter logic [127:0] UID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data
);

  logic [7:0] nxt_rd_data;

  generate
    if (BYTES != 16) begin : g_bad
      $error("sfdr_uid_rom serves exactly sixteen bytes.");
    end
  endgenerate

  // ****************************************************************
  // Byte select, most significant byte at index zero
  // ****************************************************************
  always_comb begin
    nxt_rd_data = UID[8'(127 - 8 * int'(rd_idx)) -: 8];
  end

  // Registered read keeps the output free of decode glitches.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= nxt_rd_data;
    end
  end

endmodule
`default_nettype wire
